/* bec_device.sv */
// burst error unit: register array, correction stepping and status flags
`timescale 1ns/10ps
`default_nettype none
module bec_device
    import bec_pkg::*;
(
    input  wire logic clk_in,
    input  wire logic reset_n_in,
    bec_if.device     bus
);
    localparam int FW = BEC_FACTOR_W;
    logic                   bclk_d_r;
    logic                   init_d_r;
    logic [BEC_ARRAY_W-1:0] array_r;
    logic [BEC_ARRAY_W-1:0] array_nxt;
    logic                   found_r;
    logic [BEC_FACTORS-2:0] match_r;
    logic                   align_r;
    logic [BEC_BYTE_W-1:0]  q_r;
    logic [BEC_LOW_W-1:0]   lp_r;
    logic                   step;
    logic                   init_clr;
    logic                   corr_fn;
    logic                   hs_fn;
    logic [FW-1:0]          fac    [BEC_FACTORS];
    logic [FW-1:0]          fac_nx [BEC_FACTORS];
    logic                   isolated;
    logic                   aligned;

    assign step     = bus.byte_clock & ~bclk_d_r;
    assign init_clr = ~bus.initialize_n & init_d_r;
    assign corr_fn  = (bus.function_select == BEC_FN_CORR_NORM)
                   || (bus.function_select == BEC_FN_CORR_HS);
    assign hs_fn    = bus.function_select == BEC_FN_CORR_HS;
    // pattern isolated: only the low twelve bits of factor one are set,
    // and the low byte holds part of it so a byte step cannot skip it
    assign isolated = (fac[0][FW-1:BEC_PATTERN_W] == '0)
                   && (fac[0][BEC_PATTERN_W-1:0] != '0)
                   && aligned;
    // byte stepping can only land the pattern on byte boundaries
    assign aligned  = fac[0][BEC_BYTE_W-1:0] != '0;

    // byte clock history; resets to the quiescent high level
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            bclk_d_r <= 1'b1;
        end else begin
            bclk_d_r <= bus.byte_clock;
        end
    end

    // initialize history so a held-low level clears only once
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            init_d_r <= 1'b1;
        end else begin
            init_d_r <= bus.initialize_n;
        end
    end

    // one slice per factor register; factors two to four also carry a match flag
    genvar g;
    generate
        for (g = 0; g < BEC_FACTORS; g++) begin : g_fac
            logic [FW-1:0] cur;
            logic [FW-1:0] one;
            logic [FW-1:0] eight;
            logic          go;
            assign cur = array_r[g*FW +: FW];
            assign fac[g] = cur;
            assign one = cur[0] ? ((cur >> 1) ^ BEC_FB_TAPS) : (cur >> 1);
            assign eight = {cur[BEC_BYTE_W-1:0], cur[FW-1:BEC_BYTE_W]};
            // enables matter only in correct-hs; else factor one steps
            assign go = hs_fn ? bus.factor_shift_enable[g]
                              : (g == 0);
            always_comb begin
                fac_nx[g] = cur;
                if (corr_fn && go) begin
                    fac_nx[g] = align_r ? one : eight;
                end
            end
            if (g > 0) begin : g_match
                always_ff @(posedge clk_in or negedge reset_n_in) begin
                    if (!reset_n_in) begin
                        match_r[g-1] <= 1'b0;
                    end else if (init_clr || !hs_fn) begin
                        match_r[g-1] <= 1'b0;
                    end else begin
                        match_r[g-1] <= found_r
                            && (cur[BEC_PATTERN_W-1:0]
                                == fac[0][BEC_PATTERN_W-1:0]);
                    end
                end
            end
        end
    endgenerate

    always_comb begin
        array_nxt = array_r;
        if (bus.function_select == BEC_FN_READ_HS) begin
            for (int i = 0; i < BEC_FACTORS; i++) begin
                array_nxt[i*FW +: FW] = {fac[i][FW-BEC_BYTE_W-1:0],
                    fac[i][FW-1:FW-BEC_BYTE_W] ^ bus.data_byte};
            end
        end else if (bus.function_select == BEC_FN_READ_NORM
                  || bus.function_select == BEC_FN_COMPUTE) begin
            array_nxt = {array_r[BEC_ARRAY_W-BEC_BYTE_W-1:0],
                array_r[BEC_ARRAY_W-1:BEC_ARRAY_W-BEC_BYTE_W]
                ^ bus.data_byte};
        end else if (bus.function_select == BEC_FN_WRITE) begin
            array_nxt = {array_r[BEC_ARRAY_W-BEC_BYTE_W-1:0],
                array_r[BEC_ARRAY_W-1:BEC_ARRAY_W-BEC_BYTE_W]};
        end else if (corr_fn && !found_r) begin
            for (int i = 0; i < BEC_FACTORS; i++) begin
                array_nxt[i*FW +: FW] = fac_nx[i];
            end
        end else if (hs_fn) begin
            for (int i = 1; i < BEC_FACTORS; i++) begin
                if (!match_r[i-1]) begin
                    array_nxt[i*FW +: FW] = fac_nx[i];
                end
            end
        end
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            array_r <= BEC_ARRAY_RST;
        end else if (init_clr) begin
            array_r <= BEC_ARRAY_RST;
        end else if (step) begin
            array_r <= array_nxt;
        end
    end

    // found stands until the function leaves correction or an initialize
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            found_r <= 1'b0;
        end else if (init_clr || !corr_fn) begin
            found_r <= 1'b0;
        end else if (isolated) begin
            found_r <= 1'b1;
        end
    end

    // pattern stuck in bits eight to eleven: fall back to one-bit steps
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            align_r <= 1'b0;
        end else if (init_clr || !corr_fn || found_r) begin
            align_r <= 1'b0;
        end else if (!align_r && !aligned
                     && fac[0][FW-1:BEC_PATTERN_W] == '0
                     && fac[0][BEC_PATTERN_W-1:BEC_BYTE_W] != '0) begin
            align_r <= 1'b1;
        end
    end

    // byte outputs: pattern high part when requested, else top array byte
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            q_r <= '0;
        end else if (bus.pattern_output_enable) begin
            q_r <= fac[0][BEC_PATTERN_W-1:BEC_LOW_W];
        end else begin
            q_r <= array_r[BEC_ARRAY_W-1:BEC_ARRAY_W-BEC_BYTE_W];
        end
    end

    // low pattern nibble stays zero while the pattern is not requested
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            lp_r <= '0;
        end else if (bus.pattern_output_enable) begin
            lp_r <= fac[0][BEC_LOW_W-1:0];
        end else begin
            lp_r <= '0;
        end
    end

    assign bus.pattern_found       = found_r;
    assign bus.factor_match        = match_r;
    assign bus.alignment_exception = align_r;
    assign bus.register_byte_out   = q_r;
    assign bus.pattern_low_out     = lp_r;
endmodule
`default_nettype wire

/* bec_pkg.sv */
// shared constants and types for the burst error correction status block
package bec_pkg;
    localparam int BEC_BYTE_W     = 8;
    localparam int BEC_ARRAY_W    = 56;
    localparam int BEC_FACTORS    = 4;
    localparam int BEC_FACTOR_W   = 14;
    localparam int BEC_PATTERN_W  = 12;
    localparam int BEC_LOW_W      = 4;
    localparam int BEC_FUNC_W     = 3;
    localparam int BEC_CNT_W      = 20;
    localparam logic [BEC_FUNC_W-1:0] BEC_FN_COMPUTE   = 3'h0;
    localparam logic [BEC_FUNC_W-1:0] BEC_FN_WRITE     = 3'h1;
    localparam logic [BEC_FUNC_W-1:0] BEC_FN_READ_NORM = 3'h2;
    localparam logic [BEC_FUNC_W-1:0] BEC_FN_READ_HS   = 3'h3;
    localparam logic [BEC_FUNC_W-1:0] BEC_FN_CORR_NORM = 3'h4;
    localparam logic [BEC_FUNC_W-1:0] BEC_FN_CORR_HS   = 3'h5;
    localparam logic [BEC_ARRAY_W-1:0] BEC_ARRAY_RST = 56'h0;
    localparam logic [BEC_FACTOR_W-1:0] BEC_FB_TAPS = 14'h080B;
    localparam logic [3:0] BEC_HALF_BYTE_CLK = 4'h4;
    typedef enum logic [1:0] {BEC_IDLE, BEC_WAIT, BEC_FOUND} bec_state_t;
endpackage

/* bec_if.sv */
// interface joining the unit and the controller
`timescale 1ns/10ps
`default_nettype none
interface bec_if;
    import bec_pkg::*;
    logic                       byte_clock;
    logic                       initialize_n;
    logic [BEC_FUNC_W-1:0]      function_select;
    logic [BEC_FACTORS-1:0]     factor_shift_enable;
    logic                       pattern_output_enable;
    logic [BEC_BYTE_W-1:0]      data_byte;
    logic                       pattern_found;
    logic [BEC_FACTORS-2:0]     factor_match;
    logic                       alignment_exception;
    logic [BEC_BYTE_W-1:0]      register_byte_out;
    logic [BEC_LOW_W-1:0]       pattern_low_out;
    modport device (
        input  byte_clock, initialize_n, function_select,
               factor_shift_enable, pattern_output_enable, data_byte,
        output pattern_found, factor_match, alignment_exception,
               register_byte_out, pattern_low_out
    );
    modport controller (
        output byte_clock, initialize_n, function_select,
               factor_shift_enable, pattern_output_enable, data_byte,
        input  pattern_found, factor_match, alignment_exception,
               register_byte_out, pattern_low_out
    );
endinterface
`default_nettype wire

/* bec_controller.sv */
// controller end: drives the byte clock and steps correction
`timescale 1ns/10ps
`default_nettype none
module bec_controller
    import bec_pkg::*;
(
    input  wire logic                   clk_in,
    input  wire logic                   reset_n_in,
    input  wire logic                   start_in,
    input  wire logic                   high_speed_in,
    input  wire logic                   init_req_in,
    input  wire logic                   load_in,
    input  wire logic [BEC_BYTE_W-1:0]  syndrome_in,
    output logic                        done_out,
    output logic [BEC_CNT_W-1:0]        clock_count_out,
    output logic [BEC_CNT_W-1:0]        align_count_out,
    output logic [BEC_PATTERN_W-1:0]    pattern_out,
    bec_if.controller                   bus
);
    bec_state_t             state_r;
    logic [3:0]             div_r;
    logic                   bclk_r;
    logic                   init_n_r;
    logic [BEC_FUNC_W-1:0]  fn_r;
    logic [BEC_FACTORS-1:0] shen_r;
    logic                   rep_r;
    logic                   rep_d_r;
    logic [BEC_BYTE_W-1:0]  data_r;
    logic                   done_r;
    logic [BEC_CNT_W-1:0]   cnt_r;
    logic [BEC_CNT_W-1:0]   acnt_r;
    logic [BEC_PATTERN_W-1:0] pat_r;
    logic                   fall;
    logic                   rise;

    assign fall = (div_r == BEC_HALF_BYTE_CLK - 4'h1) && bclk_r;
    assign rise = (div_r == BEC_HALF_BYTE_CLK - 4'h1) && !bclk_r;

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            div_r  <= '0;
            bclk_r <= 1'b1;
        end else if (state_r != BEC_WAIT) begin
            div_r  <= '0;
            // one low pulse in idle steps a loaded syndrome byte in
            bclk_r <= !(state_r == BEC_IDLE && load_in);
        end else if (div_r == BEC_HALF_BYTE_CLK - 4'h1) begin
            div_r  <= '0;
            bclk_r <= ~bclk_r;
        end else begin
            div_r <= div_r + 4'h1;
        end
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            init_n_r <= 1'b1;
        end else begin
            init_n_r <= ~init_req_in;
        end
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            state_r <= BEC_IDLE;
            fn_r    <= BEC_FN_READ_NORM;
            shen_r  <= '0;
            rep_r   <= 1'b0;
            done_r  <= 1'b0;
            cnt_r   <= '0;
            acnt_r  <= '0;
            pat_r   <= '0;
            rep_d_r <= 1'b0;
            data_r  <= '0;
        end else begin
            case (state_r)
                BEC_IDLE: begin
                    rep_r   <= 1'b0;
                    rep_d_r <= 1'b0;
                    if (load_in) begin
                        fn_r   <= BEC_FN_READ_HS;
                        data_r <= syndrome_in;
                    end else if (start_in) begin
                        fn_r    <= high_speed_in ? BEC_FN_CORR_HS
                                                 : BEC_FN_CORR_NORM;
                        shen_r  <= 4'h1;
                        done_r  <= 1'b0;
                        cnt_r   <= '0;
                        acnt_r  <= '0;
                        state_r <= BEC_WAIT;
                    end
                end
                BEC_WAIT: begin
                    if (rise) begin
                        cnt_r <= cnt_r + 20'h1;
                        if (bus.alignment_exception) begin
                            acnt_r <= acnt_r + 20'h1;
                        end
                    end
                    // enables move only while the byte clock is high
                    if (bclk_r && !fall && bus.pattern_found) begin
                        shen_r <= {~bus.factor_match, 1'b0};
                        if (!high_speed_in || bus.factor_match[0]) begin
                            state_r <= BEC_FOUND;
                        end
                    end
                end
                BEC_FOUND: begin
                    shen_r  <= '0;
                    rep_r   <= 1'b1;
                    rep_d_r <= rep_r;
                    // pattern outputs are registered: one cycle behind
                    if (rep_d_r) begin
                        pat_r   <= {bus.register_byte_out,
                                    bus.pattern_low_out};
                        done_r  <= 1'b1;
                        state_r <= BEC_IDLE;
                    end
                end
                default: begin
                    state_r <= BEC_IDLE;
                end
            endcase
        end
    end

    assign bus.byte_clock            = bclk_r;
    assign bus.initialize_n          = init_n_r;
    assign bus.function_select       = fn_r;
    assign bus.factor_shift_enable   = shen_r;
    assign bus.pattern_output_enable = rep_r;
    assign bus.data_byte             = data_r;
    assign done_out                  = done_r;
    assign clock_count_out           = cnt_r;
    assign align_count_out           = acnt_r;
    assign pattern_out               = pat_r;
endmodule
`default_nettype wire

/* bec_props.sv */
// assertions on the link between the unit and the controller
`timescale 1ns/10ps
`default_nettype none
module bec_props
    import bec_pkg::*;
(
    input  wire logic                   clk_in,
    input  wire logic                   reset_n_in,
    input  wire logic                   initialize_n,
    input  wire logic [BEC_FUNC_W-1:0]  function_select,
    input  wire logic                   pattern_output_enable,
    input  wire logic                   pattern_found,
    input  wire logic [BEC_FACTORS-2:0] factor_match,
    input  wire logic                   alignment_exception,
    input  wire logic [BEC_LOW_W-1:0]   pattern_low_out
);
    logic corr;
    assign corr = (function_select == BEC_FN_CORR_NORM) ||
                  (function_select == BEC_FN_CORR_HS);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!reset_n_in);
    a_init_clears_found: assert property (
        !initialize_n |-> ##[1:2] !pattern_found)
        else $error("pattern_found not cleared by initialize");
    a_found_in_corr: assert property (
        $rose(pattern_found) |-> $past(corr))
        else $error("pattern_found rose outside correction");
    a_found_stands: assert property (
        pattern_found && corr && initialize_n ##1 corr && initialize_n
        |-> pattern_found)
        else $error("pattern_found dropped during correction");
    a_match_cause: assert property (
        (factor_match & ~$past(factor_match)) != 3'h0
        |-> $past(pattern_found) && $past(function_select) == BEC_FN_CORR_HS)
        else $error("factor_match set without found in high-speed");
    a_match_clear: assert property (
        function_select != BEC_FN_CORR_HS |=> factor_match == 3'h0)
        else $error("factor_match high outside high-speed correct");
    a_pattern_gated: assert property (
        !pattern_output_enable ##1 !pattern_output_enable
        |-> pattern_low_out == 4'h0)
        else $error("pattern_low_out shown while output disabled");
    a_exc_in_corr: assert property (
        $rose(alignment_exception) |-> $past(corr))
        else $error("alignment_exception rose outside correction");
    a_init_clears_exc: assert property (
        !initialize_n |-> ##[1:2] (!alignment_exception &&
        factor_match == 3'h0))
        else $error("initialize left exception or match set");
endmodule
`default_nettype wire

/* burst_error_correction_status_test.sv */
// self-checking bench for the unit and controller pair
`timescale 1ns/10ps
`default_nettype none
module burst_error_correction_status_test;
    import bec_pkg::*;
    logic                     clk_in;
    logic                     reset_n_in;
    logic                     start_in;
    logic                     high_speed_in;
    logic                     init_req_in;
    logic                     load_in;
    logic [BEC_BYTE_W-1:0]    syndrome_in;
    logic                     done_w;
    logic [BEC_CNT_W-1:0]     clk_cnt_w;
    logic [BEC_CNT_W-1:0]     aln_cnt_w;
    logic [BEC_PATTERN_W-1:0] pat_w;
    int                       fails = 0;
    int                       n_checks = 0;
    int                       cycles = 0;
    int                       rises = 0;
    int                       aln_rises = 0;
    int                       since_edge = 0;
    int                       gaps[$];
    logic                     bclk_q = 1'b1;
    logic                     corr_q = 1'b0;
    logic [BEC_FACTORS-1:0]   shen_q = 4'h0;
    logic                     corr;
    bec_if link ();
    bec_device bec_device_inst (
        .clk_in     (clk_in),
        .reset_n_in (reset_n_in),
        .bus        (link.device)
    );
    bec_controller bec_controller_inst (
        .clk_in          (clk_in),
        .reset_n_in      (reset_n_in),
        .start_in        (start_in),
        .high_speed_in   (high_speed_in),
        .init_req_in     (init_req_in),
        .load_in         (load_in),
        .syndrome_in     (syndrome_in),
        .done_out        (done_w),
        .clock_count_out (clk_cnt_w),
        .align_count_out (aln_cnt_w),
        .pattern_out     (pat_w),
        .bus             (link.controller)
    );
    bec_props bec_props_inst (
        .clk_in                (clk_in),
        .reset_n_in            (reset_n_in),
        .initialize_n          (link.initialize_n),
        .function_select       (link.function_select),
        .pattern_output_enable (link.pattern_output_enable),
        .pattern_found         (link.pattern_found),
        .factor_match          (link.factor_match),
        .alignment_exception   (link.alignment_exception),
        .pattern_low_out       (link.pattern_low_out)
    );
    assign corr = (link.function_select === BEC_FN_CORR_NORM) ||
                  (link.function_select === BEC_FN_CORR_HS);
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks = n_checks + 1;
        if (seen !== exp) begin
            fails = fails + 1;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    initial begin
        clk_in = 1'b0;
        forever #4 clk_in = ~clk_in;
    end
    // reference model: counts byte clock rises in correction and checks edge spacing
    always @(negedge clk_in) begin
        cycles = cycles + 1;
        if (cycles > 5000) begin
            fails = fails + 1;
            tally_and_finish();
        end
        if (reset_n_in === 1'b1 && link.factor_shift_enable !== shen_q)
            check(link.byte_clock, 1'b1);
        if (link.byte_clock !== bclk_q) begin
            if (corr && corr_q && gaps.size() > 0)
                check(since_edge, 4);
            gaps.push_back(since_edge);
            since_edge = 0;
            if (corr && link.byte_clock === 1'b1) begin
                rises = rises + 1;
                if (link.alignment_exception === 1'b1)
                    aln_rises = aln_rises + 1;
            end
        end
        if (!corr)
            gaps.delete();
        since_edge = since_edge + 1;
        bclk_q = link.byte_clock;
        corr_q = corr;
        shen_q = link.factor_shift_enable;
    end
    initial begin
        logic                  hs;
        logic                  ld;
        logic [BEC_BYTE_W-1:0] syn;
        int                    n;
        reset_n_in = 1'b0;
        start_in = 1'b0;
        high_speed_in = 1'b0;
        init_req_in = 1'b0;
        load_in = 1'b0;
        syndrome_in = 8'h00;
        syn = 8'h00;
        void'($urandom(32'h6509));
        for (int run = 0; run < 6; run++) begin
            reset_n_in = 1'b0;
            repeat (8) @(negedge clk_in);
            rises = 0;
            aln_rises = 0;
            reset_n_in = 1'b1;
            @(negedge clk_in);
            check(link.byte_clock, 1'b1);
            check(link.function_select, BEC_FN_READ_NORM);
            check(link.pattern_found, 1'b0);
            // later runs load a one-byte syndrome through high-speed read
            ld = (run >= 2);
            if (ld) begin
                syn = 8'h01 + 8'($urandom_range(254));
                syndrome_in = syn;
                load_in = 1'b1;
                @(negedge clk_in);
                load_in = 1'b0;
                repeat (3) @(negedge clk_in);
                check(link.function_select, BEC_FN_READ_HS);
                check(link.pattern_found, 1'b0);
            end
            hs = run[0] ^ 1'($urandom_range(1));
            high_speed_in = hs;
            start_in = 1'b1;
            @(negedge clk_in);
            start_in = 1'b0;
            n = 40 + $urandom_range(160);
            repeat (n) @(negedge clk_in);
            check(link.function_select,
                  hs ? BEC_FN_CORR_HS : BEC_FN_CORR_NORM);
            if (hs)
                check(link.factor_shift_enable, ld ? 4'h0 : 4'h1);
            for (int k = 0; k < 10 && link.byte_clock !== 1'b1; k++)
                @(negedge clk_in);
            for (int k = 0; k < 10 && link.byte_clock !== 1'b0; k++)
                @(negedge clk_in);
            repeat (2) @(negedge clk_in);
            check(clk_cnt_w, rises);
            check(aln_cnt_w, aln_rises);
            check(link.pattern_found, ld);
            check(link.factor_match, {3{ld & hs}});
            check(link.alignment_exception, 1'b0);
            check(link.pattern_low_out, 4'h0);
            check({done_w, pat_w}, ld ? {1'b1, 4'h0, syn} : 13'h0);
            init_req_in = 1'b1;
            @(negedge clk_in);
            init_req_in = 1'b0;
            for (int k = 0; k < 3 && link.initialize_n !== 1'b0; k++)
                @(negedge clk_in);
            check(link.initialize_n, 1'b0);
            repeat (2) @(negedge clk_in);
            check(link.pattern_found, 1'b0);
        end
        tally_and_finish();
    end
endmodule
`default_nettype wire
